// file: logic/sbl_pkg.sv
// Shared constants and carrier types for the serial boot loader packet engine.
// Assumes byte-wide receive and transmit streams delivered by separate line drivers.
package sbl_pkg;

  // ==========================================================================
  // Link bytes
  localparam logic [7:0] ACK_BYTE = 8'hCC;
  localparam logic [7:0] NAK_BYTE = 8'h33;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [1:0] SYNC_COUNT = 2'h2;
  localparam logic SSI_PHASE = 1'h1;
  localparam logic SSI_POLARITY = 1'h1;

  // ==========================================================================
  // Command codes and packet lengths
  localparam logic [7:0] CMD_PING = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
  localparam logic [7:0] CMD_RUN = 8'h22;
  localparam logic [7:0] CMD_STATUS_QUERY = 8'h23;
  localparam logic [7:0] CMD_SEND_DATA = 8'h24;
  localparam logic [7:0] CMD_RESET = 8'h25;
  localparam logic [7:0] LEN_MIN = 8'h03;
  localparam logic [7:0] LEN_SHORT = 8'h03;
  localparam logic [7:0] LEN_RUN = 8'h07;
  localparam logic [7:0] LEN_DOWNLOAD = 8'h0B;
  localparam logic [7:0] REPLY_LEN = 8'h03;
  localparam logic [7:0] HDR_BYTES = 8'h02;
  localparam int BUF_DEPTH = 256;

  // ==========================================================================
  // Status codes and memory window
  localparam logic [7:0] STAT_SUCCESS = 8'h40;
  localparam logic [7:0] STAT_UNKNOWN_CMD = 8'h41;
  localparam logic [7:0] STAT_INVALID_CMD = 8'h42;
  localparam logic [7:0] STAT_INVALID_ADDR = 8'h43;
  localparam logic [7:0] STAT_FLASH_FAIL = 8'h44;
  localparam logic [7:0] STAT_RESET = 8'h40;
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_SIZE = 32'h0002_0000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    IF_NONE = 2'h0,
    IF_UART = 2'h1,
    IF_SSI = 2'h2
  } sbl_if_t;

  typedef enum logic [1:0] {
    POST_NONE = 2'h0,
    POST_REPLY = 2'h1,
    POST_RUN = 2'h2,
    POST_RESET = 2'h3
  } sbl_post_t;

  typedef struct packed {
    logic vld;
    logic [7:0] data;
  } sbl_byte_t;

  typedef struct packed {
    logic ok;
    logic [7:0] len;
    logic [7:0] cmd;
    logic [31:0] word_a;
    logic [31:0] word_b;
  } sbl_pkt_t;

  typedef struct packed {
    logic erase;
    logic [31:0] addr;
    logic [31:0] count;
    logic [7:0] data;
  } sbl_flash_t;

endpackage : sbl_pkg

// file: logic/sbl_pkt_rx.sv
// Packet receiver: frames length, checksum and payload bytes and keeps the payload.
// Assumes bytes arrive one per valid cycle on the loader clock.
`timescale 1ns/10ps
module sbl_pkt_rx (
  input wire logic clk, // Loader clock
  input wire logic resetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input sbl_pkg::sbl_byte_t rx, // Incoming byte
  output logic done, // Packet complete pulse
  output sbl_pkg::sbl_pkt_t pkt, // Parsed packet
  input wire logic [7:0] rd_idx, // Payload read index
  output logic [7:0] rd_data // Payload read data
);

  logic [7:0] mem [0:sbl_pkg::BUF_DEPTH-1];
  logic busy_r;
  logic done_r;
  logic ok_r;
  logic [7:0] idx_r;
  logic [7:0] len_r;
  logic [7:0] sum_r;
  logic [7:0] chk_r;
  logic [7:0] cmd_r;
  logic [31:0] wa_r;
  logic [31:0] wb_r;

  wire [7:0] pos = idx_r - sbl_pkg::HDR_BYTES;
  wire [7:0] sum_add = sum_r + rx.data;
  wire is_last = busy_r && (idx_r == len_r - 8'h01);
  wire start = !busy_r && (rx.data != 8'h00);
  wire short_len = rx.data < sbl_pkg::LEN_MIN;
  wire is_chk = idx_r == 8'h01;
  wire in_wa = (pos >= 8'h01) && (pos <= 8'h04);
  wire in_wb = (pos >= 8'h05) && (pos <= 8'h08);

  // ==========================================================================
  // Framing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ok_r <= 1'b0;
      idx_r <= 8'h00;
      len_r <= 8'h00;
      sum_r <= 8'h00;
      chk_r <= 8'h00;
      cmd_r <= 8'h00;
      wa_r <= 32'h0000_0000;
      wb_r <= 32'h0000_0000;
    end else if (ce) begin
      done_r <= 1'b0;
      if (rx.vld && !busy_r && start) begin
        len_r <= rx.data;
        sum_r <= 8'h00;
        idx_r <= 8'h01;
        busy_r <= !short_len;
        done_r <= short_len;
        ok_r <= 1'b0;
      end else if (rx.vld && busy_r) begin
        idx_r <= idx_r + 8'h01;
        if (is_chk) begin
          chk_r <= rx.data;
        end else begin
          sum_r <= sum_add;
          if (pos == 8'h00) begin
            cmd_r <= rx.data;
          end
          if (in_wa) begin
            wa_r <= {wa_r[23:0], rx.data};
          end
          if (in_wb) begin
            wb_r <= {wb_r[23:0], rx.data};
          end
        end
        if (is_last) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          ok_r <= sum_add == chk_r;
        end
      end
    end
  end

  // ==========================================================================
  // Payload store
  always_ff @(posedge clk) begin
    if (ce && rx.vld && busy_r && !is_chk) begin
      mem[pos] <= rx.data;
    end
  end

  assign rd_data = mem[rd_idx];
  assign done = done_r;
  assign pkt = '{ok: ok_r, len: len_r, cmd: cmd_r, word_a: wa_r, word_b: wb_r};

endmodule : sbl_pkt_rx

// file: logic/sbl_loader.sv
// Packet command engine of the serial boot loader.
// Assumes byte-level line drivers for both links and a flash controller handshake.
// Overview of operation
// - Packet starts with its total length, length and checksum bytes included.
// - Checksum byte is the sum of payload bytes only.
// - Payload holds length minus two bytes.
// - Device answers each received packet with 0xCC or 0x33.
// - Acknowledge depends only on packet reception, never on command validity.
// - Returned packet may follow zeros; then length, checksum, payload.
// - Returned packet bytes go back to back once started.
// - Device ignores zeros ahead of the host answer.
// - First payload byte is the command code, parameters follow.
// - Ping 0x20 sets status to success, nothing more.
// - Status query 0x23 returns one-byte packet with previous status.
// - Download 0x21: eleven bytes, address then count, MSB first.
// - Download erases the whole region before acknowledging.
// - Download range checked against memory; result becomes status.
// - Send-data 0x24 programs at current address and advances it.
// - Programming ends once the download byte count is reached.
// - Rejected send-data leaves the programming address unchanged.
// - Run 0x22: seven bytes, address MSB first; acknowledge, then execute.
// - Reset 0x25: acknowledge, then full software reset.
// - First link used stays the only link until reset.
// - Two 0x55 sync bytes on the async link get answered 0xCC.
// - Synchronous link uses phase and polarity both set to one.
`timescale 1ns/10ps
module sbl_loader (
  input wire logic clk, // 40 MHz loader clock
  input wire logic resetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input sbl_pkg::sbl_byte_t uart_rx, // Byte from async link
  input sbl_pkg::sbl_byte_t ssi_rx, // Byte from sync link
  output logic uart_tx_vld, // Byte offered to async link
  output logic ssi_tx_vld, // Byte offered to sync link
  input wire logic uart_tx_rdy, // Async link takes byte
  input wire logic ssi_tx_rdy, // Sync link takes byte
  output logic [7:0] tx_data, // Byte offered
  output logic clock_phase_select, // Sync link phase setting
  output logic clock_polarity_select, // Sync link polarity setting
  output sbl_pkg::sbl_if_t active_if, // Locked link
  output logic flash_vld, // Flash request pending
  output sbl_pkg::sbl_flash_t flash_req, // Flash request
  input wire logic flash_done, // Flash request finished
  input wire logic flash_err, // Flash request failed
  output logic exec_vld, // Execute pulse
  output logic [31:0] exec_addr, // Execute address
  output logic sw_reset // Software reset pulse
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROG = 3'b001,
    ST_ERASE = 3'b011,
    ST_ACK = 3'b010,
    ST_REPLY = 3'b110,
    ST_HRESP = 3'b111
  } sbl_state_t;

  // ==========================================================================
  // Decoding helpers
  function automatic logic len_ok(input logic [7:0] cmd, input logic [7:0] len);
    logic r;
    r = 1'b0;
    case (cmd)
      sbl_pkg::CMD_DOWNLOAD: r = len == sbl_pkg::LEN_DOWNLOAD;
      sbl_pkg::CMD_RUN: r = len == sbl_pkg::LEN_RUN;
      sbl_pkg::CMD_SEND_DATA: r = len > sbl_pkg::LEN_SHORT;
      default: r = len == sbl_pkg::LEN_SHORT;
    endcase
    return r;
  endfunction : len_ok

  // ==========================================================================
  // State
  sbl_state_t state_r, state_nxt;
  sbl_pkg::sbl_if_t if_r, if_nxt;
  sbl_pkg::sbl_post_t post_r, post_nxt;
  logic [1:0] sync_r, sync_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic dl_r, dl_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] remain_r, remain_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [7:0] end_r, end_nxt;
  logic [1:0] rcnt_r, rcnt_nxt;
  logic fv_r, fv_nxt;
  logic [31:0] xaddr_r, xaddr_nxt;
  logic xvld_r, xvld_nxt;
  logic swr_r, swr_nxt;

  sbl_pkg::sbl_byte_t rx_in;
  sbl_pkg::sbl_pkt_t pkt;
  logic pkt_done;
  logic [7:0] rd_data;

  // ==========================================================================
  // Link selection
  wire idle = state_r == ST_IDLE;
  wire if_none = if_r == sbl_pkg::IF_NONE;
  wire if_uart = if_r == sbl_pkg::IF_UART;
  wire if_ssi = if_r == sbl_pkg::IF_SSI;
  // Sync bytes only before either link locks
  wire sync_byte = if_none && uart_rx.vld && (uart_rx.data == sbl_pkg::SYNC_BYTE);
  wire sync_hit = sync_byte && (sync_r == sbl_pkg::SYNC_COUNT - 2'h1);
  // Sync link locks on its first non-zero byte unless the async link speaks
  wire ssi_take = ssi_rx.vld && (if_ssi || (if_none && !uart_rx.vld));
  wire ssi_lock = if_none && ssi_take && (ssi_rx.data != 8'h00);
  wire uart_take = if_uart && uart_rx.vld;
  wire [7:0] src_data = if_uart ? uart_rx.data : ssi_rx.data;
  wire src_vld = uart_take || ssi_take;
  assign rx_in = '{vld: idle && src_vld, data: src_data};
  // Zeros ahead of the host answer are ignored
  wire host_resp = src_vld && (src_data != 8'h00);

  // Byte held offered until taken, next one follows at once
  wire tx_on = (state_r == ST_ACK) || (state_r == ST_REPLY);
  wire tx_fire = tx_on && (if_uart ? uart_tx_rdy : ssi_tx_rdy);

  // Region must sit inside the memory window
  wire [32:0] dl_end = {1'b0, pkt.word_a} + {1'b0, pkt.word_b};
  wire [32:0] win_end = {1'b0, sbl_pkg::FLASH_BASE} + {1'b0, sbl_pkg::FLASH_SIZE};
  wire range_ok = (pkt.word_a >= sbl_pkg::FLASH_BASE) && (dl_end <= win_end);
  wire prog_stop = (idx_r == end_r) || (remain_r == 32'h0000_0000);

  sbl_pkt_rx u_rx (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .rx(rx_in),
    .done(pkt_done),
    .pkt(pkt),
    .rd_idx(idx_r),
    .rd_data(rd_data)
  );

  // ==========================================================================
  // Command sequencing
  always_comb begin
    state_nxt = state_r;
    if_nxt = if_r;
    post_nxt = post_r;
    sync_nxt = sync_r;
    status_nxt = status_r;
    tx_nxt = tx_r;
    dl_nxt = dl_r;
    addr_nxt = addr_r;
    remain_nxt = remain_r;
    idx_nxt = idx_r;
    end_nxt = end_r;
    rcnt_nxt = rcnt_r;
    fv_nxt = fv_r;
    xaddr_nxt = xaddr_r;
    xvld_nxt = 1'b0;
    swr_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (sync_byte) begin
          sync_nxt = sync_r + 2'h1;
        end
        if (sync_hit) begin
          // Lock to the async link and confirm with 0xCC
          if_nxt = sbl_pkg::IF_UART;
          tx_nxt = sbl_pkg::ACK_BYTE;
          post_nxt = sbl_pkg::POST_NONE;
          state_nxt = ST_ACK;
        end else if (ssi_lock) begin
          if_nxt = sbl_pkg::IF_SSI;
        end
        if (pkt_done) begin
          state_nxt = ST_ACK;
          post_nxt = sbl_pkg::POST_NONE;
          tx_nxt = pkt.ok ? sbl_pkg::ACK_BYTE : sbl_pkg::NAK_BYTE;
          if (pkt.ok && !len_ok(pkt.cmd, pkt.len)) begin
            status_nxt = sbl_pkg::STAT_INVALID_CMD;
          end else if (pkt.ok) begin
            unique case (pkt.cmd)
              sbl_pkg::CMD_PING: status_nxt = sbl_pkg::STAT_SUCCESS;
              sbl_pkg::CMD_STATUS_QUERY: post_nxt = sbl_pkg::POST_REPLY;
              sbl_pkg::CMD_DOWNLOAD: begin
                dl_nxt = 1'b0;
                if (range_ok) begin
                  // Erase before the answer goes out
                  addr_nxt = pkt.word_a;
                  remain_nxt = pkt.word_b;
                  fv_nxt = 1'b1;
                  state_nxt = ST_ERASE;
                end else begin
                  status_nxt = sbl_pkg::STAT_INVALID_ADDR;
                end
              end
              sbl_pkg::CMD_SEND_DATA: begin
                if (dl_r) begin
                  idx_nxt = 8'h01;
                  end_nxt = pkt.len - sbl_pkg::HDR_BYTES;
                  status_nxt = sbl_pkg::STAT_SUCCESS;
                  state_nxt = ST_PROG;
                end else begin
                  status_nxt = sbl_pkg::STAT_INVALID_CMD;
                end
              end
              sbl_pkg::CMD_RUN: begin
                xaddr_nxt = pkt.word_a;
                status_nxt = sbl_pkg::STAT_SUCCESS;
                post_nxt = sbl_pkg::POST_RUN;
              end
              sbl_pkg::CMD_RESET: post_nxt = sbl_pkg::POST_RESET;
              default: status_nxt = sbl_pkg::STAT_UNKNOWN_CMD;
            endcase
          end
          // Rejected packets leave address and count untouched
        end
      end
      ST_ERASE: begin
        if (flash_done) begin
          fv_nxt = 1'b0;
          dl_nxt = !flash_err;
          status_nxt = flash_err ? sbl_pkg::STAT_FLASH_FAIL : sbl_pkg::STAT_SUCCESS;
          state_nxt = ST_ACK;
        end
      end
      ST_PROG: begin
        if (fv_r) begin
          if (flash_done) begin
            fv_nxt = 1'b0;
            addr_nxt = addr_r + 32'h0000_0001;
            remain_nxt = remain_r - 32'h0000_0001;
            idx_nxt = idx_r + 8'h01;
            if (flash_err) begin
              status_nxt = sbl_pkg::STAT_FLASH_FAIL;
              end_nxt = idx_r + 8'h01;
            end
          end
        end else if (prog_stop) begin
          // Sequence closes after the packet's last data byte or at the download count
          dl_nxt = (remain_r != 32'h0000_0000) && (status_r == sbl_pkg::STAT_SUCCESS);
          state_nxt = ST_ACK;
        end else begin
          fv_nxt = 1'b1;
        end
      end
      ST_ACK: begin
        if (tx_fire) begin
          state_nxt = ST_IDLE;
          unique case (post_r)
            sbl_pkg::POST_REPLY: begin
              // Reply starts with its length byte
              tx_nxt = sbl_pkg::REPLY_LEN;
              rcnt_nxt = 2'h0;
              state_nxt = ST_REPLY;
            end
            // Execute only after the answer left
            sbl_pkg::POST_RUN: xvld_nxt = 1'b1;
            sbl_pkg::POST_RESET: begin
              // Reset after the answer; the engine restarts too
              swr_nxt = 1'b1;
              if_nxt = sbl_pkg::IF_NONE;
              sync_nxt = 2'h0;
              dl_nxt = 1'b0;
              status_nxt = sbl_pkg::STAT_RESET;
            end
            default: state_nxt = ST_IDLE;
          endcase
        end
      end
      ST_REPLY: begin
        if (tx_fire) begin
          // One-byte payload: checksum equals the status
          tx_nxt = status_r;
          rcnt_nxt = rcnt_r + 2'h1;
          if (rcnt_r == 2'h2) begin
            state_nxt = ST_HRESP;
          end
        end
      end
      ST_HRESP: begin
        // Any non-zero answer closes the exchange
        if (host_resp) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      if_r <= sbl_pkg::IF_NONE;
      post_r <= sbl_pkg::POST_NONE;
      sync_r <= 2'h0;
      status_r <= sbl_pkg::STAT_RESET;
      tx_r <= 8'h00;
      dl_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      remain_r <= 32'h0000_0000;
      idx_r <= 8'h00;
      end_r <= 8'h00;
      rcnt_r <= 2'h0;
      fv_r <= 1'b0;
      xaddr_r <= 32'h0000_0000;
      xvld_r <= 1'b0;
      swr_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      if_r <= if_nxt;
      post_r <= post_nxt;
      sync_r <= sync_nxt;
      status_r <= status_nxt;
      tx_r <= tx_nxt;
      dl_r <= dl_nxt;
      addr_r <= addr_nxt;
      remain_r <= remain_nxt;
      idx_r <= idx_nxt;
      end_r <= end_nxt;
      rcnt_r <= rcnt_nxt;
      fv_r <= fv_nxt;
      xaddr_r <= xaddr_nxt;
      xvld_r <= xvld_nxt;
      swr_r <= swr_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign uart_tx_vld = tx_on && if_uart;
  assign ssi_tx_vld = tx_on && if_ssi;
  assign tx_data = tx_r;
  // Sync link fixed to phase one, polarity one
  assign clock_phase_select = sbl_pkg::SSI_PHASE;
  assign clock_polarity_select = sbl_pkg::SSI_POLARITY;
  assign active_if = if_r;
  assign flash_vld = fv_r;
  assign flash_req = '{erase: state_r == ST_ERASE, addr: addr_r, count: remain_r,
                       data: rd_data};
  assign exec_vld = xvld_r;
  assign exec_addr = xaddr_r;
  assign sw_reset = swr_r;

endmodule : sbl_loader

// file: testbench/sbl_loader_asserts.sv
// Checker on the loader's link, flash and control ports.
// Assumes ce high during transfers; bound to every sbl_loader instance.
`timescale 1ns/10ps
module sbl_loader_chk (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic uart_tx_vld, // Async offer
  input wire logic ssi_tx_vld, // Sync offer
  input wire logic uart_tx_rdy, // Async take
  input wire logic ssi_tx_rdy, // Sync take
  input wire logic [7:0] tx_data, // Offered byte
  input wire logic clock_phase_select, // Phase
  input wire logic clock_polarity_select, // Polarity
  input wire logic flash_vld, // Flash request
  input sbl_pkg::sbl_flash_t flash_req, // Flash fields
  input wire logic flash_done, // Flash finished
  input wire logic exec_vld, // Execute pulse
  input wire logic sw_reset // Soft reset pulse
);
  logic ack_out;
  assign ack_out = ((uart_tx_vld && uart_tx_rdy) || (ssi_tx_vld && ssi_tx_rdy))
    && tx_data == sbl_pkg::ACK_BYTE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ====
  // Link and flash
  chk_one_link: assert property (!(uart_tx_vld && ssi_tx_vld))
    else $error("both links offered");
  chk_sync_mode: assert property (clock_phase_select && clock_polarity_select)
    else $error("sync link mode wrong");
  chk_tx_stands: assert property (uart_tx_vld && !uart_tx_rdy |=> uart_tx_vld && $stable(tx_data))
    else $error("offered byte dropped");
  chk_erase_quiet: assert property (flash_vld |-> !uart_tx_vld && !ssi_tx_vld)
    else $error("answer during flash work");
  chk_flash_hold: assert property (flash_vld && !flash_done |=> flash_vld && $stable(flash_req))
    else $error("flash request changed");
  chk_flash_end: assert property (flash_vld && flash_done |=> !flash_vld)
    else $error("flash request not ended");
  chk_run_ack: assert property ($rose(exec_vld) |-> $past(ack_out) ##1 !exec_vld)
    else $error("execute without ack");
  chk_reset_ack: assert property ($rose(sw_reset) |-> $past(ack_out) ##1 !sw_reset)
    else $error("soft reset without ack");
  cov_run: cover property (exec_vld);
  cov_reset: cover property (sw_reset);
  cov_erase: cover property (flash_vld && flash_req.erase && flash_done);
endmodule : sbl_loader_chk

bind sbl_loader sbl_loader_chk u_chk (.clk(clk), .resetn(resetn), .uart_tx_vld(uart_tx_vld),
  .ssi_tx_vld(ssi_tx_vld), .uart_tx_rdy(uart_tx_rdy), .ssi_tx_rdy(ssi_tx_rdy),
  .tx_data(tx_data), .clock_phase_select(clock_phase_select),
  .clock_polarity_select(clock_polarity_select), .flash_vld(flash_vld),
  .flash_req(flash_req), .flash_done(flash_done), .exec_vld(exec_vld), .sw_reset(sw_reset));

// file: testbench/sbl_host_mdl.sv
// Host link and flash controller model facing the loader.
// Assumes the bench calls send and reads got, prog and erased.
`timescale 1ns/10ps
module sbl_host_mdl (
  input wire logic clk, // Clock
  output sbl_pkg::sbl_byte_t uart_rx, // Byte to device
  output sbl_pkg::sbl_byte_t ssi_rx, // Byte to device, sync link
  input wire logic uart_tx_vld, // Device offers byte
  output logic uart_tx_rdy, // Host takes byte
  input wire logic [7:0] tx_data, // Offered byte
  input wire logic flash_vld, // Flash request
  input sbl_pkg::sbl_flash_t flash_req, // Flash fields
  output logic flash_done, // Flash finished
  output logic flash_err // Flash failed
);
  logic [7:0] got[$];
  logic [31:0] prog[$];
  logic [63:0] erased = '0;
  logic stall = 1'b0;
  int dly = 3;
  int cnt = 0;
  initial begin
    uart_rx = '0;
    ssi_rx = '0;
    uart_tx_rdy = 1'b1;
    flash_done = 1'b0;
    flash_err = 1'b0;
  end
  // ====
  // host byte stream, released data inverted
  task automatic send(input logic [7:0] b[$], input bit on_ssi = 1'b0);
    foreach (b[i]) begin
      @(posedge clk);
      #2;
      if (on_ssi) ssi_rx = {1'b1, b[i]};
      else uart_rx = {1'b1, b[i]};
    end
    @(posedge clk);
    #2;
    if (on_ssi) ssi_rx = {1'b0, ~ssi_rx.data};
    else uart_rx = {1'b0, ~uart_rx.data};
  endtask : send
  always @(posedge clk) begin
    ssi_rx.data <= ~ssi_rx.data;
    uart_tx_rdy <= !stall || !uart_tx_rdy;
    if (uart_tx_vld && uart_tx_rdy) got.push_back(tx_data);
    flash_done <= 1'b0;
    if (flash_vld && !flash_done) begin
      cnt <= cnt + 1;
      if (cnt >= dly) begin
        flash_done <= 1'b1;
        cnt <= 0;
        if (flash_req.erase) erased <= {flash_req.addr, flash_req.count};
        else prog.push_back({flash_req.addr[23:0], flash_req.data});
      end
    end
  end
endmodule : sbl_host_mdl

// file: testbench/sbl_loader_tb.sv
// Self-checking bench for the loader packet engine on the async and sync links.
// Assumes the host model handles flash and async link handshakes.
`timescale 1ns/10ps
module sbl_loader_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic ssi_tx_rdy = 1'b1;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_rst = 0;
  int n_ssi = 0;
  logic [7:0] ssi_byte = '0;
  logic [31:0] run_addr = '0;
  sbl_pkg::sbl_byte_t uart_rx, ssi_rx;
  sbl_pkg::sbl_if_t active_if;
  sbl_pkg::sbl_flash_t flash_req;
  logic uart_tx_vld, ssi_tx_vld, uart_tx_rdy, flash_vld, flash_done, flash_err;
  logic exec_vld, sw_reset, ph, pol;
  logic [7:0] tx_data;
  logic [31:0] exec_addr;
  sbl_loader uut (.clk(clk), .resetn(resetn), .ce(ce), .uart_rx(uart_rx), .ssi_rx(ssi_rx),
    .uart_tx_vld(uart_tx_vld), .ssi_tx_vld(ssi_tx_vld), .uart_tx_rdy(uart_tx_rdy),
    .ssi_tx_rdy(ssi_tx_rdy), .tx_data(tx_data), .clock_phase_select(ph),
    .clock_polarity_select(pol), .active_if(active_if), .flash_vld(flash_vld),
    .flash_req(flash_req), .flash_done(flash_done), .flash_err(flash_err),
    .exec_vld(exec_vld), .exec_addr(exec_addr), .sw_reset(sw_reset));
  sbl_host_mdl mdl (.clk(clk), .uart_rx(uart_rx), .ssi_rx(ssi_rx), .uart_tx_vld(uart_tx_vld),
    .uart_tx_rdy(uart_tx_rdy), .tx_data(tx_data), .flash_vld(flash_vld),
    .flash_req(flash_req), .flash_done(flash_done), .flash_err(flash_err));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (exec_vld === 1'b1) run_addr <= exec_addr;
    if (sw_reset === 1'b1) n_rst <= n_rst + 1;
    if (ssi_tx_vld === 1'b1 && ssi_tx_rdy) begin
      ssi_byte <= tx_data;
      n_ssi <= n_ssi + 1;
    end
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // ====
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, act);
    end
  endtask : chk
  task automatic reply(input logic [7:0] exp);
    logic [7:0] b;
    b = 8'h00;
    for (int n = 0; n < 400 && b == 8'h00; n++) begin
      @(posedge clk);
      #2;
      if (mdl.got.size() > 0) b = mdl.got.pop_front();
    end
    chk("reply", {24'h0, exp}, {24'h0, b});
  endtask : reply
  task automatic pkt(input logic [7:0] p[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (p[i]) s += p[i];
    mdl.send({8'(p.size() + 2), s, p});
  endtask : pkt
  task automatic status(input logic [7:0] exp);
    pkt({sbl_pkg::CMD_STATUS_QUERY});
    reply(sbl_pkg::ACK_BYTE);
    reply(sbl_pkg::REPLY_LEN);
    reply(exp);
    reply(exp);
    mdl.send({8'h00, sbl_pkg::ACK_BYTE});
  endtask : status
  // ====
  // Scenarios
  task automatic t_sync;
    mdl.send({sbl_pkg::SYNC_BYTE, sbl_pkg::SYNC_BYTE});
    reply(sbl_pkg::ACK_BYTE);
    chk("link", 32'h1, {30'h0, active_if});
    chk("ssi mode", 32'h3, {30'h0, ph, pol});
    $display("sync done");
  endtask : t_sync
  task automatic t_bad;
    mdl.send({8'h03, 8'h21, sbl_pkg::CMD_PING});
    reply(sbl_pkg::NAK_BYTE);
    mdl.send({8'h02});
    reply(sbl_pkg::NAK_BYTE);
    $display("bad packets done");
  endtask : t_bad
  task automatic t_cmds;
    ce = 1'b0;
    pkt({sbl_pkg::CMD_PING});
    repeat (4) @(posedge clk);
    #2;
    chk("frozen", 32'h0, 32'(mdl.got.size()));
    ce = 1'b1;
    pkt({8'h30});
    reply(sbl_pkg::ACK_BYTE);
    status(sbl_pkg::STAT_UNKNOWN_CMD);
    pkt({sbl_pkg::CMD_SEND_DATA, 8'h11});
    reply(sbl_pkg::ACK_BYTE);
    status(sbl_pkg::STAT_INVALID_CMD);
    pkt({sbl_pkg::CMD_PING});
    reply(sbl_pkg::ACK_BYTE);
    status(sbl_pkg::STAT_SUCCESS);
    $display("commands done");
  endtask : t_cmds
  task automatic t_dl;
    mdl.stall = 1'b1;
    pkt({sbl_pkg::CMD_DOWNLOAD, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01});
    reply(sbl_pkg::ACK_BYTE);
    status(sbl_pkg::STAT_INVALID_ADDR);
    pkt({sbl_pkg::CMD_DOWNLOAD, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02});
    reply(sbl_pkg::ACK_BYTE);
    chk("erase addr", 32'h100, mdl.erased[63:32]);
    chk("erase count", 32'h2, mdl.erased[31:0]);
    status(sbl_pkg::STAT_SUCCESS);
    mdl.stall = 1'b0;
    $display("download done");
  endtask : t_dl
  task automatic t_data;
    pkt({sbl_pkg::CMD_SEND_DATA, 8'hA5});
    reply(sbl_pkg::ACK_BYTE);
    mdl.send({8'h04, 8'h00, sbl_pkg::CMD_SEND_DATA, 8'h5A});
    reply(sbl_pkg::NAK_BYTE);
    pkt({sbl_pkg::CMD_SEND_DATA, 8'h5A});
    reply(sbl_pkg::ACK_BYTE);
    pkt({sbl_pkg::CMD_SEND_DATA, 8'h77});
    reply(sbl_pkg::ACK_BYTE);
    chk("prog count", 32'h2, 32'(mdl.prog.size()));
    chk("prog 0", 32'h0001_00A5, mdl.prog[0]);
    chk("prog 1", 32'h0001_015A, mdl.prog[1]);
    $display("send data done");
  endtask : t_data
  task automatic t_end;
    pkt({sbl_pkg::CMD_RUN, 8'h00, 8'h00, 8'h12, 8'h34});
    reply(sbl_pkg::ACK_BYTE);
    repeat (3) @(posedge clk);
    chk("run addr", 32'h1234, run_addr);
    pkt({sbl_pkg::CMD_RESET});
    reply(sbl_pkg::ACK_BYTE);
    repeat (3) @(posedge clk);
    chk("soft resets", 32'h1, 32'(n_rst));
    chk("link", 32'h0, {30'h0, active_if});
    $display("run and reset done");
  endtask : t_end
  task automatic t_ssi;
    mdl.send({sbl_pkg::LEN_SHORT, sbl_pkg::CMD_PING, sbl_pkg::CMD_PING}, 1'b1);
    repeat (4) @(posedge clk);
    #2;
    chk("ssi reply", {24'h0, sbl_pkg::ACK_BYTE}, {24'h0, ssi_byte});
    chk("link", 32'h2, {30'h0, active_if});
    pkt({sbl_pkg::CMD_PING});
    repeat (4) @(posedge clk);
    #2;
    chk("ssi answers", 32'h1, 32'(n_ssi));
    chk("async answers", 32'h0, 32'(mdl.got.size()));
    $display("sync link done");
  endtask : t_ssi
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge clk);
    #2;
    resetn = 1'b1;
    t_sync();
    t_bad();
    t_cmds();
    t_dl();
    t_data();
    t_end();
    t_ssi();
    complete_run();
  end
endmodule : sbl_loader_tb
